/* verilog/oam_pkg.sv */
/*
 Constants, encodings and the state type shared by the operand address mode unit.
 Assumes a 16-bit general register file of eight entries and an 18-bit physical bus.
*/
package oam_pkg;

   localparam int unsigned DATA_W     = 16;
   localparam int unsigned SEL_W      = 3;
   localparam int unsigned SPEC_W     = 6;
   localparam int unsigned PA_W       = 18;
   localparam int unsigned RELOC_W    = 12;
   localparam int unsigned RELOC_SHIFT = 6;

   localparam logic [SEL_W-1:0]  SEL_STACK_PTR = 3'h6;
   localparam logic [SEL_W-1:0]  SEL_PC        = 3'h7;
   localparam logic [DATA_W-1:0] STEP_WORD     = 16'h0002;
   localparam logic [DATA_W-1:0] STEP_BYTE     = 16'h0001;
   localparam logic [DATA_W-1:0] BYTE_MASK     = 16'h00FF;
   localparam logic [DATA_W-1:0] ZERO_WORD     = 16'h0000;
   localparam logic [PA_W-1:0]   ZERO_PA       = 18'h00000;

   typedef enum logic [2:0] {
      OAM_MODE_REG        = 3'b000,
      OAM_MODE_REG_DEF    = 3'b001,
      OAM_MODE_AUTOINC    = 3'b010,
      OAM_MODE_AUTOINC_DEF = 3'b011,
      OAM_MODE_AUTODEC    = 3'b100,
      OAM_MODE_AUTODEC_DEF = 3'b101,
      OAM_MODE_INDEX      = 3'b110,
      OAM_MODE_INDEX_DEF  = 3'b111
   } oam_mode_t;

   typedef enum logic [2:0] {
      OAM_ST_IDLE     = 3'b000,
      OAM_ST_WAIT_RD  = 3'b001,
      OAM_ST_EVAL     = 3'b010,
      OAM_ST_PC_WAIT  = 3'b011,
      OAM_ST_IDX_BUS  = 3'b100,
      OAM_ST_PTR_BUS  = 3'b101,
      OAM_ST_FINISH   = 3'b110
   } oam_state_t;

endpackage

/* verilog/oam_rf_if.sv */
/*
 Carrier between the address mode sequencer and its general register file.
 Assumes one clock; read data arrive one cycle after the read select.
*/
`timescale 1ns/100ps
interface oam_rf_if;
   logic [2:0]  rd_sel;
   logic [15:0] rd_data;
   logic        wr_en;
   logic [2:0]  wr_sel;
   logic [15:0] wr_data;

   modport user (output rd_sel, input rd_data, output wr_en, output wr_sel, output wr_data);
   modport store (input rd_sel, output rd_data, input wr_en, input wr_sel, input wr_data);
endinterface

/* verilog/oam_regfile.sv */
/*
 Eight-entry general register file with a registered read port.
 Assumes the user never needs a write to bypass into the same-cycle read.
*/
`timescale 1ns/100ps
module oam_regfile (
   input  wire logic clk_sys_i,
   input  wire logic rst_b_i,
   oam_rf_if.store   rf
);
   import oam_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] rd_data;
   } oam_rf_state_t;

   logic [DATA_W-1:0] mem_q [0:7];
   oam_rf_state_t     st_reg;
   oam_rf_state_t     st_next;

   always_comb begin
      st_next = st_reg;
      st_next.rd_data = mem_q[rf.rd_sel];
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
      if (rf.wr_en) begin
         mem_q[rf.wr_sel] <= rf.wr_data;
      end
   end

   assign rf.rd_data = st_reg.rd_data;
endmodule // oam_regfile

/* verilog/oam_unit.sv */
/*
 Operand address mode unit: evaluates one or two operand specifiers, applies
 register side effects, fetches extension and pointer words, relocates addresses.
 Assumes bus_ack_i and the request inputs come from logic on clk_sys_i.
 The register file answers one cycle after its select, so each read is chosen a state early.
*/
`timescale 1ns/100ps
module oam_unit (
   input  wire logic                           clk_sys_i,
   input  wire logic                           rst_b_i,
   input  wire logic                           start_i,
   input  wire logic                           double_i,
   input  wire logic                           byte_i,
   input  wire logic [oam_pkg::SPEC_W-1:0]     src_spec_i,
   input  wire logic [oam_pkg::SPEC_W-1:0]     dst_spec_i,
   input  wire logic                           gr_wr_en_i,
   input  wire logic [oam_pkg::SEL_W-1:0]      gr_wr_sel_i,
   input  wire logic [oam_pkg::DATA_W-1:0]     gr_wr_data_i,
   input  wire logic [oam_pkg::RELOC_W-1:0]    reloc_base_i,
   input  wire logic                           bus_ack_i,
   input  wire logic [oam_pkg::DATA_W-1:0]     bus_rdata_i,
   output logic                                busy_o,
   output logic                                bus_req_o,
   output logic [oam_pkg::PA_W-1:0]            bus_addr_o,
   output logic                                spec_done_o,
   output logic                                spec_is_dst_o,
   output logic                                is_reg_o,
   output logic [oam_pkg::DATA_W-1:0]          operand_o,
   output logic [oam_pkg::DATA_W-1:0]          ea_o,
   output logic [oam_pkg::PA_W-1:0]            phys_addr_o,
   output logic [oam_pkg::DATA_W-1:0]          hardware_stack_pointer_o,
   output logic                                extended_integer_instructions_o,
   output logic                                floating_point_instructions_o
);
   import oam_pkg::*;

   typedef struct packed {
      oam_state_t        st;
      logic              dst_phase;
      logic              double_op;
      logic              byte_op;
      logic [SPEC_W-1:0] spec;
      logic [SPEC_W-1:0] dst_spec;
      logic [SEL_W-1:0]  rd_sel;
      logic [DATA_W-1:0] reg_val;
      logic [DATA_W-1:0] ptr;
      logic              busy;
      logic              bus_req;
      logic [PA_W-1:0]   bus_addr;
      logic              done;
      logic              is_dst;
      logic              is_reg;
      logic [DATA_W-1:0] operand;
      logic [DATA_W-1:0] ea;
      logic [PA_W-1:0]   phys;
      logic [DATA_W-1:0] stack_ptr;
      logic              extended_integer_instructions;
      logic              floating_point_instructions;
   } oam_top_state_t;

   oam_top_state_t    s_reg;
   oam_top_state_t    s_next;
   oam_rf_if          rf ();

   oam_regfile u_regfile (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .rf        (rf)
   );

   // Virtual to physical: offset added to a base held in 64-byte blocks
   function automatic logic [PA_W-1:0] relocate(input logic [DATA_W-1:0] va,
                                                input logic [RELOC_W-1:0] base);
      logic [PA_W-1:0] base_pa;
      base_pa = PA_W'({base, RELOC_SHIFT'(0)});
      return PA_W'(base_pa + PA_W'(va));
   endfunction

   oam_mode_t         mode;
   logic [SEL_W-1:0]  sel;
   logic [DATA_W-1:0] step;
   logic [DATA_W-1:0] r_inc;
   logic [DATA_W-1:0] r_dec;
   logic [DATA_W-1:0] r_inc2;
   logic [DATA_W-1:0] r_dec2;
   logic [DATA_W-1:0] idx_base;
   logic [DATA_W-1:0] idx_sum;
   logic              rf_wr_en;
   logic [SEL_W-1:0]  rf_wr_sel;
   logic [DATA_W-1:0] rf_wr_data;

   always_comb begin
      mode = oam_mode_t'(s_reg.spec[SPEC_W-1:SEL_W]);
      sel  = s_reg.spec[SEL_W-1:0];
      // Stack pointer and PC must stay word aligned, so they never step by one
      if (s_reg.byte_op && sel != SEL_STACK_PTR && sel != SEL_PC) begin
         step = STEP_BYTE;
      end else begin
         step = STEP_WORD;
      end
      r_inc  = DATA_W'(s_reg.reg_val + step);
      r_dec  = DATA_W'(s_reg.reg_val - step);
      r_inc2 = DATA_W'(s_reg.reg_val + STEP_WORD);
      r_dec2 = DATA_W'(s_reg.reg_val - STEP_WORD);
      // For PC as index base the value is the PC after the extension word
      idx_base = (sel == SEL_PC) ? DATA_W'(s_reg.ptr + STEP_WORD) : s_reg.reg_val;
      idx_sum  = DATA_W'(bus_rdata_i + idx_base);
   end

   always_comb begin
      s_next     = s_reg;
      rf_wr_en   = 1'b0;
      rf_wr_sel  = sel;
      rf_wr_data = ZERO_WORD;
      s_next.done = 1'b0;
      s_next.extended_integer_instructions  = 1'b1;
      s_next.floating_point_instructions  = 1'b0;
      case (s_reg.st)
         OAM_ST_IDLE: begin
            s_next.busy = 1'b0;
            // External register loads only while no specifier is in flight
            if (gr_wr_en_i) begin
               rf_wr_en   = 1'b1;
               rf_wr_sel  = gr_wr_sel_i;
               rf_wr_data = gr_wr_data_i;
               if (gr_wr_sel_i == SEL_STACK_PTR) begin
                  s_next.stack_ptr = gr_wr_data_i;
               end
            end else if (start_i) begin
               s_next.busy      = 1'b1;
               s_next.spec      = src_spec_i;
               s_next.dst_spec  = dst_spec_i;
               s_next.double_op = double_i;
               s_next.byte_op   = byte_i;
               s_next.dst_phase = !double_i;
               if (!double_i) begin
                  s_next.spec = dst_spec_i;
               end
               if (double_i) begin
                  s_next.rd_sel = src_spec_i[SEL_W-1:0];
               end else begin
                  s_next.rd_sel = dst_spec_i[SEL_W-1:0];
               end
               s_next.st     = OAM_ST_WAIT_RD;
            end
         end
         OAM_ST_WAIT_RD: begin
            // Select PC now so that its value stands on the read port in PC_WAIT
            s_next.rd_sel = SEL_PC;
            s_next.st = OAM_ST_EVAL;
         end
         OAM_ST_EVAL: begin
            s_next.reg_val = rf.rd_data;
            s_next.is_reg  = 1'b0;
            s_next.st      = OAM_ST_FINISH;
            case (mode)
               OAM_MODE_REG: begin
                  s_next.is_reg  = 1'b1;
                  s_next.operand = s_reg.byte_op ? (rf.rd_data & BYTE_MASK) : rf.rd_data;
                  s_next.ea      = ZERO_WORD;
               end
               OAM_MODE_REG_DEF: begin
                  s_next.ea = rf.rd_data;
               end
               default: begin
                  // Remaining modes need reg_val registered first
                  s_next.st = OAM_ST_PC_WAIT;
               end
            endcase
            s_next.rd_sel = SEL_PC;
         end
         OAM_ST_PC_WAIT: begin
            // rd_data now holds PC; reg_val holds the selected register
            s_next.st = OAM_ST_FINISH;
            case (mode)
               OAM_MODE_AUTOINC: begin
                  s_next.ea  = s_reg.reg_val;
                  rf_wr_en   = 1'b1;
                  rf_wr_data = r_inc;
               end
               OAM_MODE_AUTOINC_DEF: begin
                  s_next.ptr = s_reg.reg_val;
                  rf_wr_en   = 1'b1;
                  rf_wr_data = r_inc2;
                  s_next.st  = OAM_ST_PTR_BUS;
               end
               OAM_MODE_AUTODEC: begin
                  s_next.ea  = r_dec;
                  rf_wr_en   = 1'b1;
                  rf_wr_data = r_dec;
               end
               OAM_MODE_AUTODEC_DEF: begin
                  s_next.ptr = r_dec2;
                  rf_wr_en   = 1'b1;
                  rf_wr_data = r_dec2;
                  s_next.st  = OAM_ST_PTR_BUS;
               end
               default: begin
                  // Index modes: extension word sits at the current PC
                  s_next.ptr = rf.rd_data;
                  s_next.st  = OAM_ST_IDX_BUS;
               end
            endcase
            if (rf_wr_en && sel == SEL_STACK_PTR) begin
               s_next.stack_ptr = rf_wr_data;
            end
            if (s_next.st == OAM_ST_PTR_BUS || s_next.st == OAM_ST_IDX_BUS) begin
               s_next.bus_req  = 1'b1;
               s_next.bus_addr = relocate(s_next.ptr, reloc_base_i);
            end
         end
         OAM_ST_IDX_BUS: begin
            if (bus_ack_i) begin
               s_next.bus_req = 1'b0;
               rf_wr_en   = 1'b1;
               rf_wr_sel  = SEL_PC;
               rf_wr_data = DATA_W'(s_reg.ptr + STEP_WORD);
               if (mode == OAM_MODE_INDEX_DEF) begin
                  // Request drops for a cycle so each fetch gets its own acknowledge
                  s_next.ptr      = idx_sum;
                  s_next.bus_addr = relocate(idx_sum, reloc_base_i);
                  s_next.st       = OAM_ST_PTR_BUS;
               end else begin
                  s_next.ea = idx_sum;
                  s_next.st = OAM_ST_FINISH;
               end
            end
         end
         OAM_ST_PTR_BUS: begin
            if (!s_reg.bus_req) begin
               // Pointer fetch after an index word: raise the address set last cycle
               s_next.bus_req = 1'b1;
            end else if (bus_ack_i) begin
               s_next.bus_req = 1'b0;
               s_next.ea      = bus_rdata_i;
               s_next.st      = OAM_ST_FINISH;
            end
         end
         OAM_ST_FINISH: begin
            s_next.done = 1'b1;
            // Phase flag moves on below, so the pulsed result keeps its own copy
            s_next.is_dst = s_reg.dst_phase;
            if (s_reg.is_reg) begin
               s_next.phys = ZERO_PA;
            end else begin
               s_next.phys = relocate(s_reg.ea, reloc_base_i);
            end
            if (!s_reg.dst_phase) begin
               // Source done; destination follows with the same decoding
               s_next.dst_phase = 1'b1;
               s_next.spec      = s_reg.dst_spec;
               s_next.rd_sel    = s_reg.dst_spec[SEL_W-1:0];
               s_next.st        = OAM_ST_WAIT_RD;
            end else begin
               s_next.busy = 1'b0;
               s_next.st   = OAM_ST_IDLE;
            end
         end
         default: begin
            s_next.st = OAM_ST_IDLE;
         end
      endcase
   end

   assign rf.rd_sel  = s_reg.rd_sel;
   assign rf.wr_en   = rf_wr_en;
   assign rf.wr_sel  = rf_wr_sel;
   assign rf.wr_data = rf_wr_data;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         s_reg    <= '0;
         s_reg.st <= OAM_ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // Result fields stay valid from the done pulse until the next specifier reaches EVAL; phys_addr_o and spec_is_dst_o until it ends
   assign busy_o                          = s_reg.busy;
   assign bus_req_o                       = s_reg.bus_req;
   assign bus_addr_o                      = s_reg.bus_addr;
   assign spec_done_o                     = s_reg.done;
   assign spec_is_dst_o                   = s_reg.is_dst;
   assign is_reg_o                        = s_reg.is_reg;
   assign operand_o                       = s_reg.operand;
   assign ea_o                            = s_reg.ea;
   assign phys_addr_o                     = s_reg.phys;
   assign hardware_stack_pointer_o        = s_reg.stack_ptr;
   assign extended_integer_instructions_o = s_reg.extended_integer_instructions;
   assign floating_point_instructions_o   = s_reg.floating_point_instructions;
endmodule // oam_unit

/* verification/oam_unit_asserts.sv */
/* Port assertions for the operand address mode unit.
   Assumes binding to oam_unit, with reloc_base_i steady around each result. */
`timescale 1ns/100ps
module oam_unit_asserts
   import oam_pkg::*;
(
   input wire logic                        clk_sys_i,
   input wire logic                        rst_b_i,
   input wire logic                        start_i,
   input wire logic                        double_i,
   input wire logic                        gr_wr_en_i,
   input wire logic [oam_pkg::SEL_W-1:0]   gr_wr_sel_i,
   input wire logic [oam_pkg::DATA_W-1:0]  gr_wr_data_i,
   input wire logic [oam_pkg::RELOC_W-1:0] reloc_base_i,
   input wire logic                        bus_ack_i,
   input wire logic [oam_pkg::SPEC_W-1:0]  dst_spec_i,
   input wire logic                        busy_o,
   input wire logic                        bus_req_o,
   input wire logic [oam_pkg::PA_W-1:0]    bus_addr_o,
   input wire logic                        spec_done_o,
   input wire logic                        is_reg_o,
   input wire logic [oam_pkg::DATA_W-1:0]  ea_o,
   input wire logic [oam_pkg::PA_W-1:0]    phys_addr_o,
   input wire logic [oam_pkg::DATA_W-1:0]  hardware_stack_pointer_o,
   input wire logic                        extended_integer_instructions_o,
   input wire logic                        floating_point_instructions_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   logic taken;
   assign taken = start_i && !busy_o && !gr_wr_en_i && !double_i;
   a_fp_absent: assert property (floating_point_instructions_o == 1'b0)
      else $error("floating point flag raised");
   a_eis_present: assert property ($past(rst_b_i) |-> extended_integer_instructions_o)
      else $error("extended integer flag low");
   a_reg_fast: assert property (taken && dst_spec_i[5:3] == 3'h0 |->
      ##1 (!bus_req_o) [*3] ##1 (spec_done_o && is_reg_o))
      else $error("register operand late or used the bus");
   a_step_latency: assert property (taken && dst_spec_i[2:0] != 3'h7 &&
      (dst_spec_i[5:3] == 3'h2 || dst_spec_i[5:3] == 3'h4) |-> ##5 spec_done_o)
      else $error("autostep result not on time");
   a_reg_clear: assert property (spec_done_o && is_reg_o |-> ea_o == 16'h0000 && phys_addr_o == 18'h00000)
      else $error("register result carries an address");
   a_reloc_sum: assert property (spec_done_o && !is_reg_o |->
      phys_addr_o == {reloc_base_i, 6'h00} + {2'h0, ea_o})
      else $error("physical address not relocated");
   a_req_hold: assert property (bus_req_o && !bus_ack_i |=> bus_req_o && $stable(bus_addr_o))
      else $error("bus request dropped or moved");
   a_req_release: assert property (bus_req_o && bus_ack_i |=> !bus_req_o)
      else $error("bus request held after ack");
   a_busy_ends: assert property ($fell(busy_o) |-> spec_done_o)
      else $error("busy ended without a result");
   a_sp_shadow: assert property (gr_wr_en_i && !busy_o && gr_wr_sel_i == 3'h6 |=>
      hardware_stack_pointer_o == $past(gr_wr_data_i))
      else $error("stack pointer shadow stale");
endmodule // oam_unit_asserts

bind oam_unit oam_unit_asserts oam_unit_asserts_i (.clk_sys_i, .rst_b_i, .start_i, .double_i,
   .gr_wr_en_i, .gr_wr_sel_i, .gr_wr_data_i, .reloc_base_i, .bus_ack_i, .dst_spec_i, .busy_o,
   .bus_req_o, .bus_addr_o, .spec_done_o, .is_reg_o, .ea_o, .phys_addr_o,
   .hardware_stack_pointer_o, .extended_integer_instructions_o, .floating_point_instructions_o);

/* verification/oam_mem_model.sv */
/* Memory on the far side of the operand fetch bus.
   Assumes requests hold until ack; slow_i adds three wait cycles per read. */
`timescale 1ns/100ps
module oam_mem_model
   import oam_pkg::*;
(
   input  wire logic                       clk_sys_i,
   input  wire logic                       slow_i,
   input  wire logic                       bus_req_i,
   input  wire logic [oam_pkg::PA_W-1:0]   bus_addr_i,
   output logic                            bus_ack_o,
   output logic [oam_pkg::DATA_W-1:0]      bus_rdata_o
);
   logic [DATA_W-1:0] mem [logic [PA_W-1:0]];
   int                wait_cnt;
   task automatic put(input logic [PA_W-1:0] a, input logic [DATA_W-1:0] d);
      mem[a] = d;
   endtask
   initial begin
      bus_ack_o = 1'b0;
      bus_rdata_o = 16'h0000;
      wait_cnt = 0;
   end
   always @(posedge clk_sys_i) begin
      if (bus_ack_o) begin
         bus_ack_o <= 1'b0;
         wait_cnt <= 0;
      end else if (bus_req_i && wait_cnt >= (slow_i ? 3 : 0)) begin
         bus_ack_o <= 1'b1;
         bus_rdata_o <= mem.exists(bus_addr_i) ? mem[bus_addr_i] : ~bus_addr_i[15:0];
      end else if (bus_req_i) begin
         wait_cnt <= wait_cnt + 1;
      end
      // Stale data must not look valid outside the ack cycle
      if (!(bus_req_i && !bus_ack_o && wait_cnt >= (slow_i ? 3 : 0))) begin
         bus_rdata_o <= ~bus_rdata_o;
      end
   end
endmodule // oam_mem_model

/* verification/oam_unit_bench.sv */
/* Self-checking bench for the operand address mode unit.
   Assumes the memory model answers every request; inputs move 1 ns after the edge. */
`timescale 1ns/100ps
module oam_unit_bench;
   import oam_pkg::*;
   logic               clk_sys_i, rst_b_i, start_i, double_i, byte_i, gr_wr_en_i, bus_ack_i;
   logic               busy_o, bus_req_o, spec_done_o, spec_is_dst_o, is_reg_o, slow;
   logic               extended_integer_instructions_o, floating_point_instructions_o;
   logic [SPEC_W-1:0]  src_spec_i, dst_spec_i;
   logic [SEL_W-1:0]   gr_wr_sel_i;
   logic [DATA_W-1:0]  gr_wr_data_i, bus_rdata_i, operand_o, ea_o, hardware_stack_pointer_o;
   logic [RELOC_W-1:0] reloc_base_i;
   logic [PA_W-1:0]    bus_addr_o, phys_addr_o;
   logic [DATA_W-1:0]  r_ea [2];
   logic [DATA_W-1:0]  r_op [2];
   logic [PA_W-1:0]    r_pa [2];
   logic               r_reg [2];
   logic               r_dst [2];
   int                 mismatches, checked;

   oam_unit oam_unit_i (.clk_sys_i, .rst_b_i, .start_i, .double_i, .byte_i, .src_spec_i,
      .dst_spec_i, .gr_wr_en_i, .gr_wr_sel_i, .gr_wr_data_i, .reloc_base_i, .bus_ack_i,
      .bus_rdata_i, .busy_o, .bus_req_o, .bus_addr_o, .spec_done_o, .spec_is_dst_o, .is_reg_o,
      .operand_o, .ea_o, .phys_addr_o, .hardware_stack_pointer_o,
      .extended_integer_instructions_o, .floating_point_instructions_o);
   oam_mem_model oam_mem_model_i (.clk_sys_i, .slow_i(slow), .bus_req_i(bus_req_o),
      .bus_addr_i(bus_addr_o), .bus_ack_o(bus_ack_i), .bus_rdata_o(bus_rdata_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic end_sim();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic miss(input string what);
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
   endtask
   task automatic chk_w(input logic [DATA_W-1:0] got, exp, input string what);
      checked++;
      if (got !== exp) miss(what);
   endtask
   task automatic chk_p(input logic [PA_W-1:0] got, exp, input string what);
      checked++;
      if (got !== exp) miss(what);
   endtask
   task automatic chk_b(input logic got, exp, input string what);
      checked++;
      if (got !== exp) miss(what);
   endtask
   function automatic logic [PA_W-1:0] pa(input logic [DATA_W-1:0] va);
      return {reloc_base_i, 6'h00} + {2'h0, va};
   endfunction
   function automatic logic [SPEC_W-1:0] spc(input logic [2:0] m, r);
      return {m, r};
   endfunction
   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(input logic [SEL_W-1:0] r, input logic [DATA_W-1:0] d);
      tick();
      {gr_wr_en_i, gr_wr_sel_i, gr_wr_data_i} = {1'b1, r, d};
      tick();
      gr_wr_en_i = 1'b0;
   endtask
   // Bounded wait: a lost result shows up as a short count, not a hang
   task automatic run(input logic dbl, byt, input logic [SPEC_W-1:0] s, d);
      int n = 0;
      tick();
      {double_i, byte_i, src_spec_i, dst_spec_i, start_i} = {dbl, byt, s, d, 1'b1};
      tick();
      start_i = 1'b0;
      for (int k = 0; k < 80 && n <= int'(dbl); k++) begin
         if (spec_done_o === 1'b1) begin
            {r_ea[n], r_op[n], r_pa[n], r_reg[n], r_dst[n]} =
               {ea_o, operand_o, phys_addr_o, is_reg_o, spec_is_dst_o};
            n++;
         end
         if (n <= int'(dbl)) tick();
      end
      chk_b(n > int'(dbl), 1'b1, "result count");
   endtask
   task automatic rd(input logic [SEL_W-1:0] r, output logic [DATA_W-1:0] v);
      run(1'b0, 1'b0, 6'h00, spc(3'h0, r));
      v = r_op[0];
   endtask

   task automatic t_register();
      logic [DATA_W-1:0] v;
      wr(3'h2, 16'h12A5);
      rd(3'h2, v);
      chk_b(r_reg[0], 1'b1, "register flag");
      chk_w(v, 16'h12A5, "register word");
      run(1'b0, 1'b1, 6'h00, spc(3'h0, 3'h2));
      chk_w(r_op[0], 16'h00A5, "register byte");
      wr(3'h1, 16'h2000);
      run(1'b0, 1'b0, 6'h00, spc(3'h1, 3'h1));
      chk_w(r_ea[0], 16'h2000, "deferred address");
      chk_p(r_pa[0], pa(16'h2000), "relocated address");
      rd(3'h1, v);
      chk_w(v, 16'h2000, "deferred keeps register");
   endtask
   task automatic t_autostep();
      logic [DATA_W-1:0] v, st;
      for (int m = 0; m < 2; m++) begin
         for (int b = 0; b < 4; b++) begin
            st = (b == 1) ? 16'h0001 : 16'h0002;
            wr(b[1] ? 3'h6 : 3'h3, 16'h2000);
            run(1'b0, b[0], 6'h00, spc(m ? 3'h4 : 3'h2, b[1] ? 3'h6 : 3'h3));
            chk_w(r_ea[0], m ? 16'h2000 - st : 16'h2000, "autostep address");
            rd(b[1] ? 3'h6 : 3'h3, v);
            chk_w(v, m ? 16'h2000 - st : 16'h2000 + st, "autostep register");
         end
      end
      chk_w(hardware_stack_pointer_o, 16'h1FFE, "stack pointer shadow");
   endtask
   task automatic t_pointer();
      logic [DATA_W-1:0] v;
      slow = 1'b1;
      wr(3'h1, 16'h2000);
      oam_mem_model_i.put(pa(16'h2000), 16'hABCE);
      run(1'b0, 1'b1, 6'h00, spc(3'h3, 3'h1));
      chk_w(r_ea[0], 16'hABCE, "autoinc deferred address");
      rd(3'h1, v);
      chk_w(v, 16'h2002, "autoinc deferred step");
      run(1'b0, 1'b1, 6'h00, spc(3'h5, 3'h1));
      chk_w(r_ea[0], 16'hABCE, "autodec deferred address");
      rd(3'h1, v);
      chk_w(v, 16'h2000, "autodec deferred step");
      slow = 1'b0;
   endtask
   task automatic t_index();
      logic [DATA_W-1:0] v;
      wr(3'h7, 16'h0100);
      wr(3'h3, 16'h0800);
      oam_mem_model_i.put(pa(16'h0100), 16'h0010);
      oam_mem_model_i.put(pa(16'h0102), 16'h0020);
      oam_mem_model_i.put(pa(16'h0820), 16'h5550);
      run(1'b0, 1'b0, 6'h00, spc(3'h6, 3'h3));
      chk_w(r_ea[0], 16'h0810, "index address");
      run(1'b0, 1'b0, 6'h00, spc(3'h7, 3'h3));
      chk_w(r_ea[0], 16'h5550, "index deferred address");
      rd(3'h3, v);
      chk_w(v, 16'h0800, "index keeps register");
      rd(3'h7, v);
      chk_w(v, 16'h0104, "counter past index words");
   endtask
   task automatic t_counter();
      logic [DATA_W-1:0] v;
      wr(3'h7, 16'h0200);
      oam_mem_model_i.put(pa(16'h0202), 16'h7770);
      oam_mem_model_i.put(pa(16'h0204), 16'h0030);
      oam_mem_model_i.put(pa(16'h0206), 16'h0040);
      oam_mem_model_i.put(pa(16'h0248), 16'h4440);
      run(1'b0, 1'b0, 6'h00, spc(3'h2, 3'h7));
      chk_w(r_ea[0], 16'h0200, "immediate word address");
      run(1'b0, 1'b0, 6'h00, spc(3'h3, 3'h7));
      chk_w(r_ea[0], 16'h7770, "absolute address");
      run(1'b0, 1'b0, 6'h00, spc(3'h6, 3'h7));
      chk_w(r_ea[0], 16'h0236, "relative address");
      run(1'b0, 1'b0, 6'h00, spc(3'h7, 3'h7));
      chk_w(r_ea[0], 16'h4440, "relative deferred address");
      rd(3'h7, v);
      chk_w(v, 16'h0208, "counter walks the stream");
   endtask
   task automatic t_double();
      wr(3'h4, 16'h3000);
      run(1'b1, 1'b0, spc(3'h2, 3'h4), spc(3'h1, 3'h4));
      chk_b(r_dst[0], 1'b0, "source first");
      chk_w(r_ea[0], 16'h3000, "source address");
      chk_b(r_dst[1], 1'b1, "destination second");
      chk_w(r_ea[1], 16'h3002, "destination sees step");
   endtask

   initial begin
      {rst_b_i, start_i, double_i, byte_i, gr_wr_en_i, slow} = '0;
      {src_spec_i, dst_spec_i, gr_wr_sel_i, gr_wr_data_i} = '0;
      reloc_base_i = 12'h015;
      {mismatches, checked} = '0;
      repeat (10) @(posedge clk_sys_i);
      #1 rst_b_i = 1'b1;
      tick();
      chk_b(extended_integer_instructions_o, 1'b1, "extended integer");
      chk_b(floating_point_instructions_o, 1'b0, "floating point");
      t_register();
      t_autostep();
      t_pointer();
      t_index();
      t_counter();
      t_double();
      end_sim();
   end
   initial begin
      repeat (8000) @(posedge clk_sys_i);
      mismatches++;
      end_sim();
   end
endmodule // oam_unit_bench
